/* csrw_consts.svh */
// Constants of the card status word: bit positions, masks, reset values.
// Assumes inclusion by csrw_pkg users only; holds definitions only.
`ifndef CSRW_CONSTS_SVH
`define CSRW_CONSTS_SVH
`define CSRW_B_ARG_RANGE 31
`define CSRW_B_ADDR_ALIGN 30
`define CSRW_B_XFER_LEN 29
`define CSRW_B_ERASE_ORDER 28
`define CSRW_B_ERASE_SELECT 27
`define CSRW_B_PROT_WRITE 26
`define CSRW_B_HOST_LOCK 25
`define CSRW_B_LOCK_CMD 24
`define CSRW_B_CMD_CHECK 23
`define CSRW_B_CMD_NOT_ALLOWED 22
`define CSRW_B_ECC_FAIL 21
`define CSRW_B_CTRL_FAULT 20
`define CSRW_B_GENERAL 19
`define CSRW_B_ID_REWRITE 16
`define CSRW_B_ERASE_SKIP 15
`define CSRW_B_ECC_OFF 14
`define CSRW_B_ERASE_CANCEL 13
`define CSRW_STATE_LSB 9
`define CSRW_B_READY_DATA 8
`define CSRW_B_EXT_ARMED 5
`define CSRW_B_AUTH_ORDER 3
// Flags cleared once the word went out in a response
`define CSRW_READ_CLR_MASK 32'hfd39a008
// Flags cleared once reported in the response to a valid command
`define CSRW_CMD_CLR_MASK 32'h00c00000
// Bits that never read other than zero
`define CSRW_RSV_MASK 32'h000600d7
`define CSRW_FLAG_RST 32'h00000000
`define CSRW_WORD_RST 32'h00000000
`endif

/* csrw_pkg.sv */
// Types shared by the card status word block.
// Assumes csrw_consts.svh supplies the numeric constants.
package csrw_pkg;
  typedef logic [31:0] csrw_word_t;
  typedef struct packed {
    logic host_lock;
    logic ecc_off;
    logic [3:0] card_state;
    logic ready_data;
    logic ext_armed;
  } csrw_level_t;
endpackage : csrw_pkg

/* csrw_status.sv */
// Card status word: sticky error flags, live status fields, and the
// response handshake between the card bus clock and the core clock.
// Assumes event pulses and levels come from core-clock logic, and the
// response request comes from link-clock logic.
`include "csrw_consts.svh"

module csrw_status
(
  input wire logic ref_clk, // Core clock, 25 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic link_clk, // Card bus clock from the host
  input wire csrw_pkg::csrw_word_t evt_set, // Flag set pulses, core clock
  input wire csrw_pkg::csrw_level_t card_lvl, // Live status levels
  input wire logic card_rst, // Card state reset pulse, core clock
  input wire logic lk_req, // Response wanted, link clock pulse
  input wire logic lk_cmd_valid, // Command of this request was valid
  output logic lk_busy, // Request in flight, link clock
  output logic lk_resp_valid, // Response word ready, one pulse
  output csrw_pkg::csrw_word_t lk_resp_word, // Word for the response
  output csrw_pkg::csrw_word_t status_now // Live word, core clock
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Positions that latch events; everything else is a level or zero
  function automatic csrw_pkg::csrw_word_t flag_bits();
    flag_bits = `CSRW_READ_CLR_MASK | `CSRW_CMD_CLR_MASK;
  endfunction : flag_bits

  // Toggle handshake: two stages that differ mean one pending event
  function automatic logic toggled
  (
    input logic a,
    input logic b
  );
    toggled = a ^ b;
  endfunction : toggled

  function automatic csrw_pkg::csrw_word_t compose_word
  (
    input csrw_pkg::csrw_word_t flags,
    input csrw_pkg::csrw_level_t lvl
  );
    csrw_pkg::csrw_word_t w;
    w = flags & flag_bits();
    w[`CSRW_B_HOST_LOCK] = lvl.host_lock;
    w[`CSRW_B_ECC_OFF] = lvl.ecc_off;
    w[`CSRW_STATE_LSB +: 4] = lvl.card_state;
    w[`CSRW_B_READY_DATA] = lvl.ready_data;
    w[`CSRW_B_EXT_ARMED] = lvl.ext_armed;
    compose_word = w & ~`CSRW_RSV_MASK;
  endfunction : compose_word

  ////////////////////////////////////////////////////////////////////////
  // Reset release, one copy per clock domain

  logic core_rst_s1_reg;
  logic core_rst_b_reg;
  logic link_rst_s1_reg;
  logic link_rst_b_reg;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      core_rst_s1_reg <= 1'h0;
      core_rst_b_reg <= 1'h0;
    end
    else
    begin
      core_rst_s1_reg <= 1'h1;
      core_rst_b_reg <= core_rst_s1_reg;
    end
  end

  // Link clock may stop between frames; reset release waits for edges
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link_rst_s1_reg <= 1'h0;
      link_rst_b_reg <= 1'h0;
    end
    else
    begin
      link_rst_s1_reg <= 1'h1;
      link_rst_b_reg <= link_rst_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link side: request toggle and response capture

  logic req_tgl_reg;
  logic req_valid_reg;
  logic ack_s1_reg;
  logic ack_s2_reg;
  logic ack_s3_reg;
  logic ack_edge;
  logic resp_valid_reg;
  csrw_pkg::csrw_word_t resp_word_reg;
  logic ack_tgl_reg;
  csrw_pkg::csrw_word_t snap_reg;

  assign lk_busy = toggled(req_tgl_reg, ack_s3_reg);
  assign ack_edge = toggled(ack_s2_reg, ack_s3_reg);

  // Requests while busy are dropped; the host paces one per response
  always_ff @(posedge link_clk or negedge link_rst_b_reg)
  begin
    if (!link_rst_b_reg)
    begin
      req_tgl_reg <= 1'h0;
    end
    else if (lk_req && !lk_busy)
    begin
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // Validity stays still for the core until the next request
  always_ff @(posedge link_clk or negedge link_rst_b_reg)
  begin
    if (!link_rst_b_reg)
    begin
      req_valid_reg <= 1'h0;
    end
    else if (lk_req && !lk_busy)
    begin
      req_valid_reg <= lk_cmd_valid;
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_b_reg)
  begin
    if (!link_rst_b_reg)
    begin
      ack_s1_reg <= 1'h0;
      ack_s2_reg <= 1'h0;
      ack_s3_reg <= 1'h0;
    end
    else
    begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_b_reg)
  begin
    if (!link_rst_b_reg)
    begin
      resp_valid_reg <= 1'h0;
    end
    else
    begin
      resp_valid_reg <= ack_edge;
    end
  end

  // Snapshot is held still by the core until the next request
  always_ff @(posedge link_clk or negedge link_rst_b_reg)
  begin
    if (!link_rst_b_reg)
    begin
      resp_word_reg <= `CSRW_WORD_RST;
    end
    else if (ack_edge)
    begin
      resp_word_reg <= snap_reg;
    end
  end

  assign lk_resp_valid = resp_valid_reg;
  assign lk_resp_word = resp_word_reg;

  ////////////////////////////////////////////////////////////////////////
  // Core side: request receive and acknowledge

  logic req_s1_reg;
  logic req_s2_reg;
  logic req_s3_reg;
  logic take;
  csrw_pkg::csrw_word_t flag_reg;

  always_ff @(posedge ref_clk or negedge core_rst_b_reg)
  begin
    if (!core_rst_b_reg)
    begin
      req_s1_reg <= 1'h0;
      req_s2_reg <= 1'h0;
      req_s3_reg <= 1'h0;
    end
    else
    begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
    end
  end

  assign take = toggled(req_s2_reg, req_s3_reg);

  always_ff @(posedge ref_clk or negedge core_rst_b_reg)
  begin
    if (!core_rst_b_reg)
    begin
      ack_tgl_reg <= 1'h0;
    end
    else if (take)
    begin
      ack_tgl_reg <= ~ack_tgl_reg;
    end
  end

  // Word is taken before the take's clear lands, so each flag a take clears is in its response
  always_ff @(posedge ref_clk or negedge core_rst_b_reg)
  begin
    if (!core_rst_b_reg)
    begin
      snap_reg <= `CSRW_WORD_RST;
    end
    else if (take)
    begin
      snap_reg <= compose_word(flag_reg, card_lvl);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags, one register per clearing rule

  csrw_pkg::csrw_word_t flag_next;
  csrw_pkg::csrw_word_t flag_set;
  csrw_pkg::csrw_word_t read_clr;
  csrw_pkg::csrw_word_t cmd_clr;
  csrw_pkg::csrw_word_t read_flag_reg;
  csrw_pkg::csrw_word_t read_flag_next;
  csrw_pkg::csrw_word_t cmd_flag_reg;
  csrw_pkg::csrw_word_t cmd_flag_next;

  // Only flag positions latch; level and reserved bits are masked off
  assign flag_set = evt_set & flag_bits();

  // Every response carries the word, so every take clears these
  always_comb
  begin
    read_clr = '0;
    if (card_rst || take)
    begin
      read_clr = `CSRW_READ_CLR_MASK;
    end
  end

  // Shown in this response, cleared by a take only when this command was valid
  always_comb
  begin
    cmd_clr = '0;
    if (card_rst || (take && req_valid_reg))
    begin
      cmd_clr = `CSRW_CMD_CLR_MASK;
    end
  end

  // Set wins over clear so a same-cycle event survives to the next read
  always_comb
  begin
    read_flag_next = (read_flag_reg & ~read_clr) | (flag_set & `CSRW_READ_CLR_MASK);
    cmd_flag_next = (cmd_flag_reg & ~cmd_clr) | (flag_set & `CSRW_CMD_CLR_MASK);
    flag_next = read_flag_next | cmd_flag_next;
  end

  // Events land before the response request of their command
  always_ff @(posedge ref_clk or negedge core_rst_b_reg)
  begin
    if (!core_rst_b_reg)
    begin
      read_flag_reg <= `CSRW_FLAG_RST;
    end
    else
    begin
      read_flag_reg <= read_flag_next;
    end
  end

  // Next-command flags live apart so their clear can differ
  always_ff @(posedge ref_clk or negedge core_rst_b_reg)
  begin
    if (!core_rst_b_reg)
    begin
      cmd_flag_reg <= `CSRW_FLAG_RST;
    end
    else
    begin
      cmd_flag_reg <= cmd_flag_next;
    end
  end

  assign flag_reg = read_flag_reg | cmd_flag_reg;

  ////////////////////////////////////////////////////////////////////////
  // Live view for core logic

  csrw_pkg::csrw_word_t now_reg;

  always_ff @(posedge ref_clk or negedge core_rst_b_reg)
  begin
    if (!core_rst_b_reg)
    begin
      now_reg <= `CSRW_WORD_RST;
    end
    else
    begin
      now_reg <= compose_word(flag_next, card_lvl);
    end
  end

  assign status_now = now_reg;

endmodule : csrw_status

/* csrw_status_checker.sv */
// Port assertions for the card status word block.
// Assumes it is bound onto csrw_status.
`include "csrw_consts.svh"
module csrw_status_checker
(
  input wire logic ref_clk, // Core clock
  input wire logic rst_b, // Reset
  input wire logic link_clk, // Link clock
  input wire csrw_pkg::csrw_word_t evt_set, // Set pulses
  input wire logic lk_req, // Request
  input wire logic lk_busy, // Busy
  input wire logic lk_resp_valid, // Answer
  input wire csrw_pkg::csrw_word_t lk_resp_word, // Word
  input wire csrw_pkg::csrw_word_t status_now // Live word
);
  sequence s_take;
    lk_req && !lk_busy;
  endsequence
  property p_rsv;
    @(posedge ref_clk) disable iff (!rst_b) (status_now & `CSRW_RSV_MASK) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_oor;
    @(posedge ref_clk) disable iff (!rst_b) $rose(status_now[31]) |-> $past(evt_set[31], 1);
  endproperty
  a_oor: assert property (p_oor) else $error("bit 31 without cause");
  property p_crc;
    @(posedge ref_clk) disable iff (!rst_b) $rose(status_now[23]) |-> $past(evt_set[23], 1);
  endproperty
  a_crc: assert property (p_crc) else $error("bit 23 without cause");
  property p_busy;
    @(posedge link_clk) disable iff (!rst_b) s_take |=> lk_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("request not taken");
  property p_answer;
    @(posedge link_clk) disable iff (!rst_b) s_take |-> ##[4:7] lk_resp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_pulse;
    @(posedge link_clk) disable iff (!rst_b) lk_resp_valid |=> !lk_resp_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("answer too long");
  property p_hold;
    @(posedge link_clk) disable iff (!rst_b)
      !lk_busy && !lk_resp_valid |=> $stable(lk_resp_word);
  endproperty
  a_hold: assert property (p_hold) else $error("word moved");
  property p_rsv_resp;
    @(posedge link_clk) disable iff (!rst_b)
      lk_resp_valid |-> (lk_resp_word & `CSRW_RSV_MASK) == 32'h0;
  endproperty
  a_rsv_resp: assert property (p_rsv_resp) else $error("reserved bit sent");
endmodule : csrw_status_checker
bind csrw_status csrw_status_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .link_clk(link_clk), .evt_set(evt_set), .lk_req(lk_req), .lk_busy(lk_busy),
  .lk_resp_valid(lk_resp_valid), .lk_resp_word(lk_resp_word), .status_now(status_now));

/* csrw_host_model.sv */
// Host side of the card bus: one status poll per toggle of poll_go.
// Assumes the bench toggles poll_go and watches resp_cnt.
module csrw_host_model
(
  input wire logic link_clk, // Link clock
  input wire logic rst_b, // Reset
  input wire logic poll_go, // Toggle asks a poll
  input wire logic poll_ok, // Poll command valid
  input wire logic lk_busy, // Busy
  input wire logic lk_resp_valid, // Answer
  input wire csrw_pkg::csrw_word_t lk_resp_word, // Word
  output logic lk_req, // Request
  output logic lk_cmd_valid, // Validity
  output csrw_pkg::csrw_word_t got_word, // Last answer
  output logic [7:0] resp_cnt // Answers seen
);
  logic go_done;
  always_ff @(posedge link_clk or negedge rst_b)
    if (!rst_b)
    begin
      lk_req <= 1'b0;
      lk_cmd_valid <= 1'b0;
      go_done <= 1'b0;
    end
    else if (lk_req && !lk_busy)
    begin
      lk_req <= 1'b0;
      lk_cmd_valid <= ~lk_cmd_valid; // Inverted once the request is taken
    end
    else if (!lk_req && poll_go != go_done)
    begin
      lk_req <= 1'b1;
      lk_cmd_valid <= poll_ok;
      go_done <= poll_go;
    end
  always_ff @(posedge link_clk or negedge rst_b)
    if (!rst_b)
      resp_cnt <= 8'h0;
    else if (lk_resp_valid)
    begin
      resp_cnt <= resp_cnt + 8'h1;
      got_word <= lk_resp_word;
    end
endmodule : csrw_host_model

/* csrw_status_tb_top.sv */
// Bench for the card status word block.
// Assumes the host model and the bound checker.
`include "csrw_consts.svh"
module csrw_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b = 1'b0;
  logic poll_go = 1'b0;
  logic poll_ok = 1'b1;
  logic card_rst = 1'b0;
  csrw_pkg::csrw_word_t evt_set = 32'h0;
  csrw_pkg::csrw_level_t card_lvl = 8'h0;
  logic lk_req, lk_cmd_valid, lk_busy, lk_resp_valid;
  csrw_pkg::csrw_word_t lk_resp_word, status_now, got_word;
  logic [7:0] resp_cnt;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  // Sticky bits 31..26, 24..19, 16, 15, 13, 3
  localparam logic [31:0] HON = 32'hfdf9a008;
  always #20 ref_clk = ~ref_clk;
  // Link clock offset so its edges never meet the stimulus edges
  initial
  begin
    #7;
    forever #40 link_clk = ~link_clk;
  end
  csrw_status dut (.ref_clk(ref_clk), .rst_b(rst_b), .link_clk(link_clk),
    .evt_set(evt_set), .card_lvl(card_lvl), .card_rst(card_rst), .lk_req(lk_req),
    .lk_cmd_valid(lk_cmd_valid), .lk_busy(lk_busy), .lk_resp_valid(lk_resp_valid),
    .lk_resp_word(lk_resp_word), .status_now(status_now));
  csrw_host_model u_host (.link_clk(link_clk), .rst_b(rst_b), .poll_go(poll_go),
    .poll_ok(poll_ok), .lk_busy(lk_busy), .lk_resp_valid(lk_resp_valid),
    .lk_resp_word(lk_resp_word), .lk_req(lk_req), .lk_cmd_valid(lk_cmd_valid),
    .got_word(got_word), .resp_cnt(resp_cnt));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic pulse(input logic [31:0] v);
    @(negedge ref_clk);
    evt_set = v;
    @(negedge ref_clk);
    evt_set = 32'h0;
    repeat (3) @(negedge ref_clk);
  endtask : pulse
  task automatic poll(input logic ok);
    logic [7:0] n0;
    n0 = resp_cnt;
    poll_ok = ok;
    poll_go = ~poll_go;
    for (int i = 0; i < 100 && resp_cnt == n0; i++)
      @(negedge ref_clk);
    @(negedge ref_clk);
    chk(resp_cnt, n0 + 8'h1);
  endtask : poll
  task automatic t_card_rst;
    pulse(32'h80000008);
    card_rst = 1'b1;
    evt_set = 32'h00000008;
    @(negedge ref_clk);
    card_rst = 1'b0;
    evt_set = 32'h0;
    repeat (2) @(negedge ref_clk);
    chk(status_now & HON, 32'h00000008);
  endtask : t_card_rst
  task automatic t_read_clear;
    logic [31:0] lw;
    card_lvl = {1'b1, 1'b1, 4'h8, 1'b1, 1'b1};
    lw = {6'h0, 1'b1, 10'h0, 1'b1, 1'b0, 4'h8, 1'b1, 2'h0, 1'b1, 5'h0};
    pulse(32'hffffffff);
    chk(status_now, HON | lw);
    poll(1'b1);
    chk(got_word, HON | lw);
    poll(1'b1);
    chk(got_word, lw);
  endtask : t_read_clear
  task automatic t_prev_cmd;
    pulse(`CSRW_CMD_CLR_MASK);
    poll(1'b0);
    chk(got_word & `CSRW_CMD_CLR_MASK, `CSRW_CMD_CLR_MASK);
    poll(1'b1);
    chk(got_word & `CSRW_CMD_CLR_MASK, `CSRW_CMD_CLR_MASK);
    poll(1'b1);
    chk(got_word & `CSRW_CMD_CLR_MASK, 32'h0);
  endtask : t_prev_cmd
  task automatic t_state;
    for (int s = 0; s < 16; s++)
    begin
      card_lvl.card_state = s[3:0];
      repeat (3) @(negedge ref_clk);
      chk(status_now & 32'h00001e00, {19'h0, s[3:0], 9'h0});
    end
  endtask : t_state
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk(status_now, `CSRW_WORD_RST);
    t_read_clear();
    t_prev_cmd();
    t_card_rst();
    t_state();
    give_verdict();
  end
endmodule : csrw_status_tb_top
